/* shared/asd_pkg.sv */
package asd_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMP_W = 12;
  localparam int DWELL_W = 16;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_PAT4_LO = 8'h1F;
  localparam logic [7:0] OFS_PAT4_HI = 8'h20;
  localparam logic [7:0] OFS_SYNTH = 8'h21;
  localparam logic [7:0] OFS_AIN = 8'h2C;
  localparam logic [7:0] OFS_SREF = 8'h3A;
  localparam logic [7:0] OFS_FDC = 8'h45;
  localparam logic [7:0] OFS_UTH_LO = 8'h47;
  localparam logic [7:0] OFS_UTH_HI = 8'h48;
  localparam logic [7:0] OFS_LTH_LO = 8'h49;
  localparam logic [7:0] OFS_LTH_HI = 8'h4A;
  localparam logic [7:0] OFS_DWELL_LO = 8'h4B;
  localparam logic [7:0] OFS_DWELL_HI = 8'h4C;

  // ****************************************************************
  // Writable bit masks and reset value
  // ****************************************************************
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_SYNTH = 8'h18;
  localparam logic [7:0] MASK_AIN = 8'h04;
  localparam logic [7:0] MASK_SREF = 8'hDE;
  localparam logic [7:0] MASK_FDC = 8'h0D;
  localparam logic [7:0] MASK_NIBBLE = 8'h0F;
  localparam logic [7:0] REG_RST = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_REG_PD = 4;
  localparam int BIT_EXT_REF = 2;
  localparam int BIT_LSB_SWAP = 7;
  localparam int BIT_FLAG_RST = 6;
  localparam int BIT_TRANS_FALL = 4;
  localparam int BIT_EDGE_FALL = 3;
  localparam int BIT_ONE_SHOT = 2;
  localparam int BIT_SREF_EN = 1;
  localparam int BIT_OVR_FORCE = 3;
  localparam int BIT_OVR_VAL = 2;
  localparam int BIT_OVR_EN = 0;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  localparam logic [3:0] TEST_USER = 4'h8;

  typedef enum logic [1:0] {
    OVR_IDLE = 2'b00,
    OVR_HIT = 2'b01,
    OVR_DWELL = 2'b11
  } asd_ovr_st_t;

endpackage

/* shared/asd_sref_if.sv */
interface asd_sref_if;
  logic edge_fall;
  logic trans_fall;
  logic valid_edge;
  modport ctrl (output edge_fall, output trans_fall, input valid_edge);
  modport det (input edge_fall, input trans_fall, output valid_edge);
endinterface

/* rtl/asd_sref_det.sv */
module asd_sref_det
  import asd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sysref_in,
  asd_sref_if.det sr
);

  typedef struct packed {
    logic prev;
    logic valid;
  } asd_det_t;

  asd_det_t s_ff;
  asd_det_t nxt_s;
  logic fall_ff;
  logic smp;

  // ****************************************************************
  // Capture on the chosen converter clock edge
  // ****************************************************************
  // The falling-edge sample gives only half a period to the selector.
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_ff <= 1'b0;
    end else begin
      fall_ff <= sysref_in;
    end
  end

  always_comb begin
    smp = sr.edge_fall ? fall_ff : sysref_in;
    nxt_s.prev = smp;
    nxt_s.valid = sr.trans_fall ? (s_ff.prev & ~smp)
                                : (~s_ff.prev & smp);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sr.valid_edge = s_ff.valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rise_detect: assert property (
    (!sr.trans_fall && !s_ff.prev && smp) |=> sr.valid_edge)
    else $error("rising sysref transition missed");
  a_fall_detect: assert property (
    (sr.trans_fall && !(s_ff.prev && !smp)) |=> !sr.valid_edge)
    else $error("falling mode flagged a wrong transition");

endmodule // asd_sref_det

/* rtl/asd_regs.sv */
// Contract
// - Pattern low byte used only in user mode.
// - Pattern high byte used only in user mode.
// - Bit 4 powers down oscillator regulator.
// - Bit 2 enables external reference on monitor.
// - Bit 7 puts status in sample LSB.
// - Bit 6 holds flags; enable bit needed.
// - Bit 4 picks rising or falling transition.
// - Bit 3 picks rising or falling clock edge.
// - Bit 2 picks continuous or next-edge mode.
// - Bit 1 enables; self-clears in one-shot.
// - Force bit drives pin to value bit.
// - Bit 0 enables fine detection.
// - Upper threshold is twelve bits, vs magnitude.
// - Lower threshold is twelve bits, vs magnitude.
// - Pin clears after dwell samples below lower.
// - All registers reset to zero.
// - Dwell count upper byte has own register.
module asd_regs
  import asd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [3:0] test_mode,
  input wire logic sysref_in,
  input wire logic [SAMP_W-1:0] sample_in,
  input wire logic [SAMP_W-1:0] fine_mag,
  output logic [SAMP_W-1:0] sample_out,
  output logic [15:0] pattern_word,
  output logic regulator_pd,
  output logic reference_monitor_pin_ext_ref,
  output logic overrange_flag_pin,
  output logic sysref_status,
  output logic sysref_event
);

  typedef struct packed {
    logic [7:0] pat_lo;
    logic [7:0] pat_hi;
    logic [7:0] synth;
    logic [7:0] ain;
    logic [7:0] sref;
    logic [7:0] fdc;
    logic [7:0] uth_lo;
    logic [7:0] uth_hi;
    logic [7:0] lth_lo;
    logic [7:0] lth_hi;
    logic [7:0] dw_lo;
    logic [7:0] dw_hi;
    logic [7:0] rdata;
    logic rvalid;
    logic [SAMP_W-1:0] samp;
    logic [15:0] pattern;
    logic reg_pd;
    logic ext_ref;
    logic sref_flag;
    logic sref_evt;
    asd_ovr_st_t ovr_st;
    logic [DWELL_W-1:0] dwell_cnt;
    logic ovr_pin;
  } asd_state_t;

  asd_state_t s_ff;
  asd_state_t nxt_s;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic evt_ok;
  logic [SAMP_W-1:0] uth;
  logic [SAMP_W-1:0] lth;
  logic [DWELL_W:0] dwell_tgt;
  logic [DWELL_W:0] cnt_inc;

  asd_sref_if sr ();

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ****************************************************************
  // System-reference edge detection
  // ****************************************************************
  assign sr.edge_fall = s_ff.sref[BIT_EDGE_FALL];
  assign sr.trans_fall = s_ff.sref[BIT_TRANS_FALL];

  asd_sref_det u_det (
    .clk(clk),
    .rst_n(rst_n),
    .sysref_in(sysref_in),
    .sr(sr)
  );

  assign evt_ok = sr.valid_edge & s_ff.sref[BIT_SREF_EN];
  assign uth = {s_ff.uth_hi[3:0], s_ff.uth_lo};
  assign lth = {s_ff.lth_hi[3:0], s_ff.lth_lo};
  // A dwell target of zero behaves as one sample.
  assign dwell_tgt = {1'b0, s_ff.dw_hi, s_ff.dw_lo};
  assign cnt_inc = {1'b0, s_ff.dwell_cnt} + 17'h00001;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sref_evt = 1'b0;
    nxt_s.rvalid = 1'b0;

    // Hardware clear first, so a software write in the same cycle
    // re-arms the capture instead of being lost.
    if (evt_ok) begin
      nxt_s.sref_evt = 1'b1;
      if (s_ff.sref[BIT_ONE_SHOT]) begin
        nxt_s.sref[BIT_SREF_EN] = 1'b0;
      end
    end

    if (s_ff.sref[BIT_FLAG_RST]) begin
      nxt_s.sref_flag = 1'b0;
    end else if (evt_ok) begin
      nxt_s.sref_flag = 1'b1;
    end

    if (reg_wr) begin
      if (reg_addr == OFS_PAT4_LO) begin
        nxt_s.pat_lo = reg_wdata;
      end else if (reg_addr == OFS_PAT4_HI) begin
        nxt_s.pat_hi = reg_wdata;
      end else if (reg_addr == OFS_SYNTH) begin
        nxt_s.synth = reg_wdata & MASK_SYNTH;
      end else if (reg_addr == OFS_AIN) begin
        nxt_s.ain = reg_wdata & MASK_AIN;
      end else if (reg_addr == OFS_SREF) begin
        nxt_s.sref = reg_wdata & MASK_SREF;
      end else if (reg_addr == OFS_FDC) begin
        nxt_s.fdc = reg_wdata & MASK_FDC;
      end else if (reg_addr == OFS_UTH_LO) begin
        nxt_s.uth_lo = reg_wdata;
      end else if (reg_addr == OFS_UTH_HI) begin
        nxt_s.uth_hi = reg_wdata & MASK_NIBBLE;
      end else if (reg_addr == OFS_LTH_LO) begin
        nxt_s.lth_lo = reg_wdata;
      end else if (reg_addr == OFS_LTH_HI) begin
        nxt_s.lth_hi = reg_wdata & MASK_NIBBLE;
      end else if (reg_addr == OFS_DWELL_LO) begin
        nxt_s.dw_lo = reg_wdata;
      end else if (reg_addr == OFS_DWELL_HI) begin
        nxt_s.dw_hi = reg_wdata;
      end
    end

    if (reg_rd) begin
      nxt_s.rvalid = 1'b1;
      if (reg_addr == OFS_PAT4_LO) begin
        nxt_s.rdata = s_ff.pat_lo;
      end else if (reg_addr == OFS_PAT4_HI) begin
        nxt_s.rdata = s_ff.pat_hi;
      end else if (reg_addr == OFS_SYNTH) begin
        nxt_s.rdata = s_ff.synth;
      end else if (reg_addr == OFS_AIN) begin
        nxt_s.rdata = s_ff.ain;
      end else if (reg_addr == OFS_SREF) begin
        nxt_s.rdata = s_ff.sref;
      end else if (reg_addr == OFS_FDC) begin
        nxt_s.rdata = s_ff.fdc;
      end else if (reg_addr == OFS_UTH_LO) begin
        nxt_s.rdata = s_ff.uth_lo;
      end else if (reg_addr == OFS_UTH_HI) begin
        nxt_s.rdata = s_ff.uth_hi;
      end else if (reg_addr == OFS_LTH_LO) begin
        nxt_s.rdata = s_ff.lth_lo;
      end else if (reg_addr == OFS_LTH_HI) begin
        nxt_s.rdata = s_ff.lth_hi;
      end else if (reg_addr == OFS_DWELL_LO) begin
        nxt_s.rdata = s_ff.dw_lo;
      end else if (reg_addr == OFS_DWELL_HI) begin
        nxt_s.rdata = s_ff.dw_hi;
      end else begin
        nxt_s.rdata = REG_RST;
      end
    end

    // Pattern bytes reach the data path only in user input mode.
    if (test_mode == TEST_USER) begin
      nxt_s.pattern = {s_ff.pat_hi, s_ff.pat_lo};
    end else begin
      nxt_s.pattern = 16'h0000;
    end

    nxt_s.reg_pd = s_ff.synth[BIT_REG_PD];
    nxt_s.ext_ref = s_ff.ain[BIT_EXT_REF];

    if (s_ff.sref[BIT_LSB_SWAP]) begin
      nxt_s.samp = {sample_in[SAMP_W-1:1], s_ff.sref_flag};
    end else begin
      nxt_s.samp = sample_in;
    end

    // ****************************************************************
    // Threshold detector
    // ****************************************************************
    if (!s_ff.fdc[BIT_OVR_EN]) begin
      nxt_s.ovr_st = OVR_IDLE;
      nxt_s.dwell_cnt = '0;
    end else begin
      case (s_ff.ovr_st)
        OVR_IDLE: begin
          if (fine_mag > uth) begin
            nxt_s.ovr_st = OVR_HIT;
          end
          nxt_s.dwell_cnt = '0;
        end
        OVR_HIT, OVR_DWELL: begin
          if (fine_mag > uth) begin
            nxt_s.ovr_st = OVR_HIT;
            nxt_s.dwell_cnt = '0;
          end else if (fine_mag < lth) begin
            if (cnt_inc >= dwell_tgt) begin
              nxt_s.ovr_st = OVR_IDLE;
              nxt_s.dwell_cnt = '0;
            end else begin
              nxt_s.ovr_st = OVR_DWELL;
              nxt_s.dwell_cnt = cnt_inc[DWELL_W-1:0];
            end
          end else begin
            // A sample between the thresholds restarts the dwell.
            nxt_s.ovr_st = OVR_HIT;
            nxt_s.dwell_cnt = '0;
          end
        end
        default: begin
          nxt_s.ovr_st = OVR_IDLE;
          nxt_s.dwell_cnt = '0;
        end
      endcase
    end

    if (s_ff.fdc[BIT_OVR_FORCE]) begin
      nxt_s.ovr_pin = s_ff.fdc[BIT_OVR_VAL];
    end else begin
      nxt_s.ovr_pin = (nxt_s.ovr_st != OVR_IDLE);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = s_ff.rdata;
  assign reg_rvalid = s_ff.rvalid;
  assign sample_out = s_ff.samp;
  assign pattern_word = s_ff.pattern;
  assign regulator_pd = s_ff.reg_pd;
  assign reference_monitor_pin_ext_ref = s_ff.ext_ref;
  assign overrange_flag_pin = s_ff.ovr_pin;
  assign sysref_status = s_ff.sref_flag;
  assign sysref_event = s_ff.sref_evt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic wr_sref;
  logic wr_ovr;
  assign wr_sref = reg_wr && (reg_addr == OFS_SREF);
  assign wr_ovr = reg_wr && (reg_addr >= OFS_FDC);

  sequence s_synth_pd_write;
    reg_wr && (reg_addr == OFS_SYNTH) && reg_wdata[BIT_REG_PD];
  endsequence

  sequence s_oneshot_edge;
    evt_ok && s_ff.sref[BIT_ONE_SHOT] && !wr_sref;
  endsequence

  a_pattern_low: assert property (
    (pattern_word != 16'h0000) |-> $past(test_mode) == TEST_USER)
    else $error("pattern word driven outside user mode");
  a_pattern_high: assert property (
    (test_mode == TEST_USER) && !reg_wr |=>
      pattern_word[15:8] == $past(s_ff.pat_hi))
    else $error("pattern high byte not passed in user mode");
  a_regulator_pd: assert property (
    s_synth_pd_write |=> ##1 regulator_pd)
    else $error("regulator power-down not applied");
  a_ext_ref_sel: assert property (
    reference_monitor_pin_ext_ref |-> $past(s_ff.ain[BIT_EXT_REF]))
    else $error("monitor pin function without control bit");
  a_lsb_swap: assert property (
    s_ff.sref[BIT_LSB_SWAP] |=> sample_out[0] == $past(sysref_status))
    else $error("sample LSB not replaced by status");
  a_flag_hold: assert property (
    s_ff.sref[BIT_FLAG_RST] |=> !sysref_status)
    else $error("status flag not held in reset");
  a_oneshot_clear: assert property (
    s_oneshot_edge |=> !s_ff.sref[BIT_SREF_EN] ##1 !sysref_event)
    else $error("one-shot capture did not disarm");
  a_edge_gate: assert property (
    sysref_event |-> $past(s_ff.sref[BIT_SREF_EN]))
    else $error("capture while inputs disabled");
  a_force_pin: assert property (
    s_ff.fdc[BIT_OVR_FORCE] |=>
      overrange_flag_pin == $past(s_ff.fdc[BIT_OVR_VAL]))
    else $error("forced detect pin value wrong");
  a_detect_off: assert property (
    !s_ff.fdc[BIT_OVR_EN] && !s_ff.fdc[BIT_OVR_FORCE] |=>
      !overrange_flag_pin)
    else $error("detect pin set while detection off");
  a_upper_hit: assert property (
    s_ff.fdc[BIT_OVR_EN] && !wr_ovr && (fine_mag > uth) |=>
      overrange_flag_pin || s_ff.fdc[BIT_OVR_FORCE])
    else $error("upper threshold crossing missed");
  a_dwell_hold: assert property (
    s_ff.fdc[BIT_OVR_EN] && !s_ff.fdc[BIT_OVR_FORCE] && !wr_ovr &&
      (s_ff.ovr_st != OVR_IDLE) && (cnt_inc < dwell_tgt) |=>
      overrange_flag_pin)
    else $error("detect pin released before dwell ends");
  a_reset_zero: assert property (
    $rose(rst_n) |-> (s_ff.sref == REG_RST) && (s_ff.fdc == REG_RST))
    else $error("register not zero after reset");
  a_unused_zero: assert property (
    ((s_ff.fdc & ~MASK_FDC) == 8'h00) && ((s_ff.sref & ~MASK_SREF) == 8'h00))
    else $error("unused register bits not zero");

endmodule // asd_regs

/* test/asd_host.sv */
module asd_host
  import asd_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // Host side of the register port
  // ********
  // Released lines carry the inverse of the last value.
  // A design that samples them late then sees a wrong value.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // asd_host

/* test/tb_top.sv */
module tb_top
  import asd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LIMIT = 6000;
  localparam logic [7:0] ADRS [12] = '{8'h1F, 8'h20, 8'h21, 8'h2C,
    8'h3A, 8'h45, 8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C};
  localparam logic [7:0] MSKS [12] = '{8'hFF, 8'hFF, 8'h18, 8'h04,
    8'hDE, 8'h0D, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'hFF};
  localparam logic [7:0] SCFG [8] = '{8'h02, 8'h12, 8'h0A, 8'h1A,
    8'h06, 8'h16, 8'h0E, 8'h00};

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [3:0] test_mode;
  logic sysref_in;
  logic [11:0] sample_in;
  logic [11:0] fine_mag;
  logic [11:0] sample_out;
  logic [15:0] pattern_word;
  logic regulator_pd;
  logic ext_ref;
  logic overrange_flag_pin;
  logic sysref_status;
  logic sysref_event;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  int ev_cnt = 0;
  int ev_hi = 0;
  logic [7:0] rdv;
  logic rvv;

  asd_regs u_dut (.clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .test_mode, .sysref_in, .sample_in,
    .fine_mag, .sample_out, .pattern_word, .regulator_pd,
    .reference_monitor_pin_ext_ref(ext_ref), .overrange_flag_pin,
    .sysref_status, .sysref_event);

  asd_host u_host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid);

  always #20 clk = ~clk;

  // ********
  // Checking helpers
  // ********
  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rdv, rvv);
    chk({15'h0000, rvv}, 16'h0001);
    chk({8'h00, rdv}, {8'h00, e});
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Pulses are long enough that the half-cycle extra latency of
  // falling-edge capture still lands inside the same level.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      sysref_in <= 1'b1;
      repeat (5) @(posedge clk);
      sysref_in <= 1'b0;
      repeat (5) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    #1;
  endtask

  function automatic int exp_ev(input logic [7:0] c, input int n);
    return !c[1] ? 0 : (c[2] ? 1 : n);
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      summarize();
    end
  end

  always @(posedge clk) begin
    if (sysref_event === 1'b1) begin
      ev_cnt++;
      if (sysref_in === 1'b1) begin
        ev_hi++;
      end
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    logic [7:0] d;
    logic [7:0] hi;
    logic [11:0] s;
    logic [11:0] up;
    logic [11:0] lo;
    logic [15:0] dw;
    int e0;
    int h0;
    int eh;
    void'($urandom(69));
    test_mode = 4'h0;
    sysref_in = 1'b0;
    sample_in = 12'h000;
    fine_mag = 12'h000;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (ADRS[i]) rchk(ADRS[i], 8'h00);
    rchk(8'h4D, 8'h00);
    foreach (ADRS[i]) begin
      d = 8'($urandom);
      u_host.wr(ADRS[i], d);
      rchk(ADRS[i], d & MSKS[i]);
      u_host.wr(ADRS[i], 8'h00);
    end
    u_host.wr(8'h30, 8'hFF);
    rchk(8'h30, 8'h00);
    u_host.wr(8'h21, 8'h10);
    u_host.wr(8'h2C, 8'h04);
    settle();
    chk(16'(regulator_pd), 16'h0001);
    chk(16'(ext_ref), 16'h0001);
    u_host.wr(8'h21, 8'h08);
    u_host.wr(8'h2C, 8'h00);
    settle();
    chk(16'(regulator_pd), 16'h0000);
    chk(16'(ext_ref), 16'h0000);
    d = 8'($urandom);
    hi = 8'($urandom);
    u_host.wr(8'h1F, d);
    u_host.wr(8'h20, hi);
    @(posedge clk);
    test_mode <= 4'h8;
    settle();
    chk(pattern_word, {hi, d});
    @(posedge clk);
    test_mode <= 4'($urandom_range(0, 7));
    settle();
    chk(pattern_word, 16'h0000);
    foreach (SCFG[i]) begin
      u_host.wr(8'h3A, SCFG[i]);
      e0 = ev_cnt;
      h0 = ev_hi;
      pulses(3);
      chk(16'(ev_cnt - e0), 16'(exp_ev(SCFG[i], 3)));
      eh = SCFG[i][4] ? 0 : exp_ev(SCFG[i], 3);
      chk(16'(ev_hi - h0), 16'(eh));
      rchk(8'h3A, SCFG[i][2] ? SCFG[i] & 8'hFC : SCFG[i]);
    end
    chk(16'(sysref_status), 16'h0001);
    u_host.wr(8'h3A, 8'h42);
    pulses(1);
    chk(16'(sysref_status), 16'h0000);
    s = 12'($urandom);
    @(posedge clk);
    sample_in <= s;
    u_host.wr(8'h3A, 8'h82);
    settle();
    chk(16'(sample_out), {4'h0, s[11:1], 1'b0});
    pulses(1);
    chk(16'(sample_out), {4'h0, s[11:1], 1'b1});
    u_host.wr(8'h3A, 8'h00);
    settle();
    chk(16'(sample_out), {4'h0, s});
    up = 12'($urandom_range(12'h100, 12'hEFF));
    lo = up - 12'h080;
    dw = 16'(256 + $urandom_range(0, 255));
    u_host.wr(8'h47, up[7:0]);
    u_host.wr(8'h48, {4'hF, up[11:8]});
    u_host.wr(8'h49, lo[7:0]);
    u_host.wr(8'h4A, {4'h0, lo[11:8]});
    u_host.wr(8'h4B, dw[7:0]);
    u_host.wr(8'h4C, dw[15:8]);
    @(posedge clk);
    fine_mag <= up + 12'($urandom_range(1, 16));
    settle();
    chk(16'(overrange_flag_pin), 16'h0000);
    @(posedge clk);
    fine_mag <= up;
    u_host.wr(8'h45, 8'h01);
    settle();
    chk(16'(overrange_flag_pin), 16'h0000);
    @(posedge clk);
    fine_mag <= up + 12'($urandom_range(1, 16));
    settle();
    chk(16'(overrange_flag_pin), 16'h0001);
    @(posedge clk);
    fine_mag <= lo;
    repeat (dw + 4) @(posedge clk);
    #1;
    chk(16'(overrange_flag_pin), 16'h0001);
    @(posedge clk);
    fine_mag <= lo - 12'h001;
    repeat (dw - 1) @(posedge clk);
    #1;
    chk(16'(overrange_flag_pin), 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(overrange_flag_pin), 16'h0000);
    u_host.wr(8'h45, 8'h0D);
    settle();
    chk(16'(overrange_flag_pin), 16'h0001);
    @(posedge clk);
    fine_mag <= up + 12'h001;
    u_host.wr(8'h45, 8'h09);
    settle();
    chk(16'(overrange_flag_pin), 16'h0000);
    u_host.wr(8'h45, 8'h01);
    settle();
    chk(16'(overrange_flag_pin), 16'h0001);
    u_host.wr(8'h45, 8'h00);
    settle();
    chk(16'(overrange_flag_pin), 16'h0000);
    summarize();
  end
endmodule // tb_top
